// ### pkg/rscl_pkg.sv
// Constants, field layout and carrier types of the reset strap config latch.
// Assumes one 100 MHz clock and a 16-bit shared port sampled synchronously.
//
// What this block does
// - Fetch starts at address zero after reset
// - After end-of-init, refuse protected access and instructions
// - Sample shared port pins while reset runs
// - Pulled-down pin reads 0, open pin 1
// - High byte: clock, address, chip-select, strobe fields
// - Clock code maps to multiplier, default 111
// - Fractional multiplier codes need the fuller variant
// - Upper-address code picks address lines versus I/O
// - Chip-select count and write-strobe style decode
// - L7-L6 pick reset bus type, first select
// - Bootstrap, adapter, emulation selects are active low
// - Init code may rewrite; regions set by software
// - First chip select covers all unassigned space
package rscl_pkg;

  // ----------------------------------------
  // Widths and counts
  // ----------------------------------------
  localparam int CFG_W = 16;
  localparam int ADDR_W = 24;
  localparam int PAGE_W = 12;
  localparam int CS_PINS = 5;
  localparam int CAP_CNT_W = 4;
  localparam logic [CAP_CNT_W-1:0] CAPTURE_LAST = 4'h7;

  // ----------------------------------------
  // Values at reset
  // ----------------------------------------
  localparam logic [CFG_W-1:0] CFG_RESET_WORD = 16'hFFFF;
  localparam logic [ADDR_W-1:0] RESET_FETCH_ADDR = 24'h000000;
  localparam logic [2:0] CLK_SEL_DEFAULT = 3'h7;

  // ----------------------------------------
  // Field positions in the captured word
  // ----------------------------------------
  localparam int CLK_SEL_LSB = 13;
  localparam int SAL_SEL_LSB = 11;
  localparam int CS_SEL_LSB = 9;
  localparam int WRC_BIT = 8;
  localparam int BUS_SEL_LSB = 6;
  localparam int BSL_BIT = 4;
  localparam int ADP_BIT = 1;
  localparam int EMU_BIT = 0;

  // ----------------------------------------
  // Decode tables, highest code in the top slot
  // ----------------------------------------
  // Multiplier times two: x4 x3 x2 x5 x1 x1.5 x0.5 x2.5
  localparam logic [31:0] CLK_MULT_X2_LUT = 32'h864A2315;
  // Codes 010, 001, 000 exist only on the fuller variant
  localparam logic [7:0] CLK_FULL_ONLY_MASK = 8'h07;
  // Upper address lines for codes 11 10 01 00
  localparam logic [15:0] SAL_LINES_LUT = 16'h2804;
  localparam logic [3:0] UPPER_PORT_PINS = 4'h8;
  // Chip selects for codes 11 10 01 00
  localparam logic [11:0] CS_COUNT_LUT = 12'hA13;

  typedef enum logic [1:0] {ST_CAPTURE, ST_INIT, ST_RUN} rscl_phase_t;

  typedef struct packed {
    logic [3:0] clk_mult_x2;
    logic clk_code_illegal;
    logic [3:0] addr_lines;
    logic [3:0] upper_io_pins;
    logic [2:0] cs_count;
    logic wr_bhe_mode;
    logic bus_16bit;
    logic bus_mux;
    logic bootstrap_active;
    logic adapter_active;
    logic emulation_active;
  } rscl_cfg_t;

  typedef struct packed {
    logic en;
    logic [PAGE_W-1:0] base;
    logic [PAGE_W-1:0] limit;
    logic [3:0] wait_states;
  } rscl_region_t;

endpackage

// ### src/rscl_region_decode.sv
// Chip-select window decoder for the reset strap config latch.
// Assumes region windows are programmed by software in 4 KiB pages.
`timescale 1ns/100ps
`default_nettype none

module rscl_region_decode
  import rscl_pkg::*;
#(
  parameter int NUM_REGIONS = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire rscl_region_t i_regions [NUM_REGIONS],
  input wire logic [2:0] i_cs_count,
  input wire logic [3:0] i_first_wait,
  output logic [CS_PINS-1:0] o_cs_n,
  output logic [3:0] o_wait
);

  logic [CS_PINS-1:0] cs_n_d;
  logic [3:0] wait_d;
  logic hit;
  logic any_en;

  function automatic logic in_window(input logic [ADDR_W-1:0] a, input rscl_region_t r);
    logic [PAGE_W-1:0] page;
    page = a[ADDR_W-1 -: PAGE_W];
    return r.en && (page >= r.base) && (page <= r.limit);
  endfunction

  // ----------------------------------------
  // Window match, lowest region wins
  // ----------------------------------------
  always_comb begin
    cs_n_d = '1;
    wait_d = i_first_wait;
    hit = 1'b0;
    any_en = 1'b0;
    for (int k = NUM_REGIONS - 1; k >= 0; k--) begin
      any_en = any_en | i_regions[k].en;
      // Selects beyond the strapped count are plain I/O pins
      if (in_window(i_addr, i_regions[k]) && (k + 1 < int'(i_cs_count))) begin
        hit = 1'b1;
        cs_n_d = '1;
        cs_n_d[k + 1] = 1'b0;
        wait_d = i_regions[k].wait_states;
      end
    end
    if (!hit && (i_cs_count != 3'h0)) begin
      cs_n_d[0] = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cs_n <= '1;
      o_wait <= 4'h0;
    end else begin
      o_cs_n <= cs_n_d;
      o_wait <= wait_d;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_CS0_COVERS_ALL: assert property (
    (!any_en && i_cs_count != 3'h0) |=> !o_cs_n[0] && (&o_cs_n[CS_PINS-1:1]))
    else $error("first chip select not active in unassigned space");

  AST_ONE_SELECT: assert property (
    $countones(~o_cs_n) <= 1)
    else $error("more than one chip select active");

endmodule

`default_nettype wire

// ### src/rscl_top.sv
// Reset strap config latch: captures the shared port during reset,
// decodes it, runs the init phase and drives the chip-select decoder.
// Assumes all inputs are synchronous to I_MCLK and straps settle early.
`timescale 1ns/100ps
`default_nettype none

module rscl_top
  import rscl_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1,
  parameter int NUM_REGIONS = 4
) (
  input wire logic I_MCLK,
  input wire logic I_RESETN,
  input wire logic [CFG_W-1:0] I_PORT_PIN,
  input wire logic I_SW_RESET,
  input wire logic I_END_OF_INIT_INSTRUCTION,
  input wire logic I_PROT_WR,
  input wire logic I_PRIV_INSTR,
  input wire logic I_CFG_WR,
  input wire logic [CFG_W-1:0] I_CFG_WDATA,
  input wire logic I_REGION_WR,
  input wire logic [$clog2(NUM_REGIONS)-1:0] I_REGION_IDX,
  input wire rscl_region_t I_REGION_CFG,
  input wire logic [3:0] I_FIRST_REGION_WAIT,
  input wire logic [ADDR_W-1:0] I_BUS_ADDR,
  output logic O_CORE_RESET,
  output logic O_INIT_MODE,
  output logic O_FETCH_VALID,
  output logic [ADDR_W-1:0] O_FETCH_ADDR,
  output logic O_PROT_REFUSED,
  output logic O_PRIV_BLOCKED,
  output logic [CFG_W-1:0] O_CFG_WORD,
  output rscl_cfg_t O_CFG,
  output logic [CS_PINS-1:0] O_CS_N,
  output logic [3:0] O_WAIT_STATES
);

  // ----------------------------------------
  // Strap decode
  // ----------------------------------------
  function automatic rscl_cfg_t decode_cfg(input logic [CFG_W-1:0] w, input logic full);
    rscl_cfg_t c;
    logic [2:0] clk_code;
    logic [1:0] sal;
    logic [1:0] cs;
    logic [1:0] bus;
    logic [3:0] cs_idx;
    clk_code = w[CLK_SEL_LSB +: 3];
    sal = w[SAL_SEL_LSB +: 2];
    cs = w[CS_SEL_LSB +: 2];
    bus = w[BUS_SEL_LSB +: 2];
    cs_idx = {1'b0, cs, 1'b0} + {2'b00, cs};
    // Fractional codes on the smaller variant fall back to the default
    c.clk_code_illegal = !full && CLK_FULL_ONLY_MASK[clk_code];
    if (c.clk_code_illegal) begin
      clk_code = CLK_SEL_DEFAULT;
    end
    c.clk_mult_x2 = CLK_MULT_X2_LUT[{clk_code, 2'b00} +: 4];
    c.addr_lines = SAL_LINES_LUT[{sal, 2'b00} +: 4];
    c.upper_io_pins = UPPER_PORT_PINS - c.addr_lines;
    c.cs_count = CS_COUNT_LUT[cs_idx +: 3];
    c.wr_bhe_mode = w[WRC_BIT];
    c.bus_16bit = bus[1];
    c.bus_mux = bus[0];
    c.bootstrap_active = !w[BSL_BIT];
    c.adapter_active = !w[ADP_BIT];
    c.emulation_active = !w[EMU_BIT];
    return c;
  endfunction

  localparam rscl_cfg_t CFG_AT_RESET = decode_cfg(CFG_RESET_WORD, FULL_VARIANT);

  // ----------------------------------------
  // Reset phase sequencer
  // ----------------------------------------
  rscl_phase_t phase_q, phase_d;
  logic [CAP_CNT_W-1:0] cap_cnt_q, cap_cnt_d;
  logic fetch_q, fetch_d;

  always_comb begin
    phase_d = phase_q;
    cap_cnt_d = cap_cnt_q;
    fetch_d = 1'b0;
    case (phase_q)
      ST_CAPTURE: begin
        if (cap_cnt_q == CAPTURE_LAST) begin
          phase_d = ST_INIT;
          fetch_d = 1'b1;
        end else begin
          cap_cnt_d = CAP_CNT_W'(cap_cnt_q + 1'b1);
        end
      end
      ST_INIT: begin
        if (I_END_OF_INIT_INSTRUCTION) begin
          phase_d = ST_RUN;
        end
      end
      ST_RUN: begin
        phase_d = ST_RUN;
      end
      default: begin
        phase_d = ST_CAPTURE;
      end
    endcase
    // Software reset reruns the whole capture, like a hardware one
    if (I_SW_RESET) begin
      phase_d = ST_CAPTURE;
      cap_cnt_d = '0;
      fetch_d = 1'b0;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      phase_q <= ST_CAPTURE;
      cap_cnt_q <= '0;
      fetch_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cap_cnt_q <= cap_cnt_d;
      fetch_q <= fetch_d;
    end
  end

  assign O_CORE_RESET = (phase_q == ST_CAPTURE);
  assign O_INIT_MODE = (phase_q == ST_INIT);
  assign O_FETCH_VALID = fetch_q;
  assign O_FETCH_ADDR = RESET_FETCH_ADDR;

  // ----------------------------------------
  // Privilege checks
  // ----------------------------------------
  logic refused_q, refused_d;
  logic blocked_q, blocked_d;

  always_comb begin
    refused_d = (phase_q == ST_RUN) && I_PROT_WR;
    blocked_d = (phase_q == ST_RUN) && I_PRIV_INSTR;
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      refused_q <= 1'b0;
      blocked_q <= 1'b0;
    end else begin
      refused_q <= refused_d;
      blocked_q <= blocked_d;
    end
  end

  assign O_PROT_REFUSED = refused_q;
  assign O_PRIV_BLOCKED = blocked_q;

  // ----------------------------------------
  // Captured configuration word
  // ----------------------------------------
  logic [CFG_W-1:0] cfg_word_q, cfg_word_d;
  rscl_cfg_t cfg_q, cfg_d;

  always_comb begin
    cfg_word_d = cfg_word_q;
    if (phase_q == ST_CAPTURE) begin
      // Open pins arrive high, pulled-down pins low; taken as seen
      cfg_word_d = I_PORT_PIN;
    end else if ((phase_q == ST_INIT) && I_CFG_WR) begin
      cfg_word_d = I_CFG_WDATA;
    end
    cfg_d = decode_cfg(cfg_word_q, FULL_VARIANT);
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cfg_word_q <= CFG_RESET_WORD;
      cfg_q <= CFG_AT_RESET;
    end else begin
      cfg_word_q <= cfg_word_d;
      cfg_q <= cfg_d;
    end
  end

  assign O_CFG_WORD = cfg_word_q;
  assign O_CFG = cfg_q;

  // ----------------------------------------
  // Region windows, programmed by software only
  // ----------------------------------------
  rscl_region_t regions_q [NUM_REGIONS];
  rscl_region_t regions_d [NUM_REGIONS];

  always_comb begin
    for (int k = 0; k < NUM_REGIONS; k++) begin
      regions_d[k] = regions_q[k];
      // Nothing from the straps places a window
      if (phase_q == ST_CAPTURE) begin
        regions_d[k] = '0;
      end else if (I_REGION_WR && (int'(I_REGION_IDX) == k)) begin
        regions_d[k] = I_REGION_CFG;
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      for (int k = 0; k < NUM_REGIONS; k++) begin
        regions_q[k] <= '0;
      end
    end else begin
      for (int k = 0; k < NUM_REGIONS; k++) begin
        regions_q[k] <= regions_d[k];
      end
    end
  end

  rscl_region_decode #(
    .NUM_REGIONS(NUM_REGIONS)
  ) u_decode (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESETN),
    .i_addr(I_BUS_ADDR),
    .i_regions(regions_q),
    .i_cs_count(cfg_q.cs_count),
    .i_first_wait(I_FIRST_REGION_WAIT),
    .o_cs_n(O_CS_N),
    .o_wait(O_WAIT_STATES)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);

  sequence s_capture_ends;
    O_CORE_RESET ##1 !O_CORE_RESET;
  endsequence

  AST_FETCH_AT_ZERO: assert property (
    s_capture_ends |-> O_FETCH_VALID && O_INIT_MODE && (O_FETCH_ADDR == 24'h000000))
    else $error("fetch did not start at address zero after reset");

  AST_CAPTURE_LENGTH: assert property (
    ($rose(O_CORE_RESET) && !I_SW_RESET) |-> O_CORE_RESET [*8])
    else $error("capture phase shorter than eight cycles");

  AST_REFUSE_AFTER_INIT: assert property (
    (phase_q == ST_RUN && I_PROT_WR) |=> O_PROT_REFUSED)
    else $error("protected write not refused after end of init");

  AST_ALLOW_IN_INIT: assert property (
    (phase_q != ST_RUN) |=> !O_PROT_REFUSED && !O_PRIV_BLOCKED)
    else $error("refusal reported outside the run phase");

  AST_PORT_SAMPLED: assert property (
    O_CORE_RESET |=> (O_CFG_WORD == $past(I_PORT_PIN)))
    else $error("port level not captured during reset");

  AST_HELD_IN_RUN: assert property (
    (phase_q == ST_RUN && !I_SW_RESET) |=> $stable(O_CFG_WORD))
    else $error("captured word changed after end of init");

  AST_CLK_DEFAULT: assert property (
    (O_CFG_WORD[15:13] == 3'h7) |=> (O_CFG.clk_mult_x2 == 4'h8))
    else $error("clock code 111 not decoded as times four");

  AST_CLK_FRACTION: assert property (
    (O_CFG_WORD[15:13] == 3'h2) |=> (O_CFG.clk_code_illegal == !FULL_VARIANT)
      && (O_CFG.clk_mult_x2 == (FULL_VARIANT ? 4'h3 : 4'h8)))
    else $error("fractional clock code mishandled for this variant");

  AST_ADDR_LINES: assert property (
    (O_CFG_WORD[12:11] == 2'h2) |=> (O_CFG.addr_lines == 4'h8) && (O_CFG.upper_io_pins == 4'h0))
    else $error("upper address code 10 not decoded as eight lines");

  AST_CS_COUNT: assert property (
    (O_CFG_WORD[10:9] == 2'h3) |=> (O_CFG.cs_count == 3'h5))
    else $error("chip select code 11 not decoded as five selects");

  AST_BUS_TYPE: assert property (
    (O_CFG_WORD[7:6] == 2'h2) |=> O_CFG.bus_16bit && !O_CFG.bus_mux)
    else $error("bus code 10 not decoded as 16-bit demultiplexed");

  AST_MODES_LOW: assert property (
    !O_CFG_WORD[4] |=> O_CFG.bootstrap_active)
    else $error("bootstrap select not active low");

  AST_ADAPTER_LOW: assert property (
    !O_CFG_WORD[ADP_BIT] |=> O_CFG.adapter_active)
    else $error("adapter select not active low");

  AST_EMULATION_LOW: assert property (
    !O_CFG_WORD[EMU_BIT] |=> O_CFG.emulation_active)
    else $error("emulation select not active low");

  AST_BLOCK_AFTER_INIT: assert property (
    (phase_q == ST_RUN && I_PRIV_INSTR) |=> O_PRIV_BLOCKED)
    else $error("privileged instruction not blocked after end of init");

  // Software reset must rerun the full capture, not skip to init
  sequence s_full_capture;
    O_CORE_RESET [*8];
  endsequence

  AST_SW_RECAPTURE: assert property (
    I_SW_RESET |=> s_full_capture)
    else $error("software reset did not rerun the capture phase");

endmodule

`default_nettype wire

// ### verif/rscl_strap_model.sv
// Board side of the shared port: pull-down straps and open pins.
// Assumes the bench marks the capture window on i_capture.
`timescale 1ns/100ps
`default_nettype none

module rscl_strap_model
  import rscl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_capture,
  input wire logic [CFG_W-1:0] i_pull_dn,
  output logic [CFG_W-1:0] o_port
);
  // Reserved low-byte pins are never strapped
  localparam logic [CFG_W-1:0] RSV_MASK = 16'h002C;
  logic [CFG_W-1:0] bus_q = 16'hA5C3;

  // Traffic settles at FFFF within 16 cycles and then holds, so late samples read as open pins
  always @(posedge i_clk) begin
    bus_q <= ~bus_q ^ {bus_q[14:0], bus_q[15]};
  end

  always_comb begin
    if (i_capture) begin
      o_port = ~i_pull_dn | RSV_MASK;
    end else begin
      o_port = bus_q;
    end
  end
endmodule

`default_nettype wire

// ### verif/test_reset_strap_config_latch.sv
// Self-checking bench of rscl_top with a strap model on the shared port.
// Assumes one 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/100ps
`default_nettype none

module test_reset_strap_config_latch;
  import rscl_pkg::*;

  logic I_MCLK = 1'b0;
  logic I_RESETN = 1'b0;
  logic [CFG_W-1:0] I_PORT_PIN;
  logic I_SW_RESET = 1'b0;
  logic I_END_OF_INIT_INSTRUCTION = 1'b0;
  logic I_PROT_WR = 1'b0;
  logic I_PRIV_INSTR = 1'b0;
  logic I_CFG_WR = 1'b0;
  logic [CFG_W-1:0] I_CFG_WDATA = 16'h0000;
  logic I_REGION_WR = 1'b0;
  logic [1:0] I_REGION_IDX = 2'h0;
  rscl_region_t I_REGION_CFG = '0;
  logic [3:0] I_FIRST_REGION_WAIT = 4'h0;
  logic [ADDR_W-1:0] I_BUS_ADDR = 24'h000000;
  logic O_CORE_RESET, O_INIT_MODE, O_FETCH_VALID, O_PROT_REFUSED, O_PRIV_BLOCKED;
  logic [ADDR_W-1:0] O_FETCH_ADDR;
  logic [CFG_W-1:0] O_CFG_WORD;
  rscl_cfg_t O_CFG;
  logic [CS_PINS-1:0] O_CS_N;
  logic [3:0] O_WAIT_STATES;
  logic [CFG_W-1:0] pull = 16'h0000;
  logic [CFG_W-1:0] w;
  logic [31:0] seed = 32'h8caf;
  int failures = 0;
  int checks = 0;

  initial begin
    forever #5 I_MCLK = ~I_MCLK;
  end

  rscl_strap_model u_straps (.i_clk(I_MCLK), .i_capture(O_CORE_RESET | I_SW_RESET),
    .i_pull_dn(pull), .o_port(I_PORT_PIN));

  rscl_top DUT (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_PORT_PIN(I_PORT_PIN),
    .I_SW_RESET(I_SW_RESET), .I_END_OF_INIT_INSTRUCTION(I_END_OF_INIT_INSTRUCTION), .I_PROT_WR(I_PROT_WR),
    .I_PRIV_INSTR(I_PRIV_INSTR), .I_CFG_WR(I_CFG_WR), .I_CFG_WDATA(I_CFG_WDATA),
    .I_REGION_WR(I_REGION_WR), .I_REGION_IDX(I_REGION_IDX), .I_REGION_CFG(I_REGION_CFG),
    .I_FIRST_REGION_WAIT(I_FIRST_REGION_WAIT), .I_BUS_ADDR(I_BUS_ADDR),
    .O_CORE_RESET(O_CORE_RESET), .O_INIT_MODE(O_INIT_MODE), .O_FETCH_VALID(O_FETCH_VALID),
    .O_FETCH_ADDR(O_FETCH_ADDR), .O_PROT_REFUSED(O_PROT_REFUSED),
    .O_PRIV_BLOCKED(O_PRIV_BLOCKED), .O_CFG_WORD(O_CFG_WORD), .O_CFG(O_CFG),
    .O_CS_N(O_CS_N), .O_WAIT_STATES(O_WAIT_STATES));

  // ----------------------------------------
  // Reference model and helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic rscl_cfg_t exp_cfg(input logic [15:0] v);
    int m2 [8] = '{1, 1, 3, 2, 10, 4, 6, 8};
    int al [4] = '{4, 0, 8, 2};
    int cs [4] = '{3, 2, 0, 5};
    rscl_cfg_t c;
    m2[0] = 5;
    c.clk_mult_x2 = 4'(m2[v[15:13]]);
    c.clk_code_illegal = 1'b0;
    c.addr_lines = 4'(al[v[12:11]]);
    c.upper_io_pins = 4'(8 - al[v[12:11]]);
    c.cs_count = 3'(cs[v[10:9]]);
    c.wr_bhe_mode = v[8];
    c.bus_16bit = v[7];
    c.bus_mux = v[6];
    c.bootstrap_active = ~v[4];
    c.adapter_active = ~v[1];
    c.emulation_active = ~v[0];
    return c;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic pulse(ref logic sig);
    @(negedge I_MCLK);
    sig = 1'b1;
    @(negedge I_MCLK);
    sig = 1'b0;
  endtask

  // Bounded wait for the init phase, then the captured word and its decode
  task automatic wait_init(input logic [15:0] ew);
    int n;
    for (n = 0; n < 30 && O_INIT_MODE !== 1'b1; n++) begin
      @(posedge I_MCLK);
      #1;
    end
    check(O_FETCH_VALID, 1'b1);
    check(O_FETCH_ADDR, 24'h000000);
    check(O_CORE_RESET, 1'b0);
    check(O_CFG_WORD, ew);
    @(posedge I_MCLK);
    #1;
    check(O_FETCH_VALID, 1'b0);
    check(O_CFG, exp_cfg(ew));
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge I_MCLK);
    failures++;
    print_verdict();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge I_MCLK);
    I_RESETN = 1'b1;
    wait_init(16'hFFFF);
    $display("power-up capture done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      pull = seed[15:0];
      pull[15:13] = 3'(~i);
      pull[12:11] = 2'(~i);
      pull[7:6] = 2'(i + 1);
      pull[10:9] = 2'(i >> 1);
      pull[1:0] = 2'(i);
      pulse(I_SW_RESET);
      wait_init(~pull | 16'h002C);
      repeat (20) @(negedge I_MCLK);
      check(O_CFG_WORD, 16'(~pull | 16'h002C));
      $display("strap set %0d done", i);
    end
    I_PROT_WR = 1'b1;
    I_PRIV_INSTR = 1'b1;
    seed = xs(seed);
    w = seed[15:0] | 16'h0600;
    I_CFG_WDATA = w;
    I_CFG_WR = 1'b1;
    @(negedge I_MCLK);
    I_PROT_WR = 1'b0;
    I_PRIV_INSTR = 1'b0;
    I_CFG_WR = 1'b0;
    check(O_PROT_REFUSED, 1'b0);
    check(O_PRIV_BLOCKED, 1'b0);
    check(O_CFG_WORD, w);
    @(negedge I_MCLK);
    check(O_CFG, exp_cfg(w));
    I_FIRST_REGION_WAIT = seed[19:16];
    I_BUS_ADDR = seed[31:8];
    repeat (2) @(negedge I_MCLK);
    check(O_CS_N, 5'b11110);
    check(O_WAIT_STATES, seed[19:16]);
    $display("init phase done");
    for (int k = 0; k < 4; k++) begin
      I_REGION_IDX = 2'(k);
      I_REGION_CFG = {1'b1, 12'(16 * (k + 1)), 12'(16 * (k + 1) + 15), 4'(k + 1)};
      pulse(I_REGION_WR);
      I_BUS_ADDR = 24'(((16 * (k + 1)) + 7) << 12);
      repeat (2) @(negedge I_MCLK);
      check(O_CS_N, 5'(~(5'b00001 << (k + 1))));
      check(O_WAIT_STATES, 4'(k + 1));
      I_BUS_ADDR = 24'hF00000;
      repeat (2) @(negedge I_MCLK);
      check(O_CS_N, 5'b11110);
    end
    $display("region decode done");
    I_END_OF_INIT_INSTRUCTION = 1'b1;
    @(negedge I_MCLK);
    I_END_OF_INIT_INSTRUCTION = 1'b0;
    check(O_INIT_MODE, 1'b0);
    I_PROT_WR = 1'b1;
    I_CFG_WDATA = ~w;
    I_CFG_WR = 1'b1;
    @(negedge I_MCLK);
    I_PROT_WR = 1'b0;
    I_PRIV_INSTR = 1'b1;
    I_CFG_WR = 1'b0;
    check(O_PROT_REFUSED, 1'b1);
    @(negedge I_MCLK);
    I_PRIV_INSTR = 1'b0;
    check(O_PROT_REFUSED, 1'b0);
    check(O_PRIV_BLOCKED, 1'b1);
    @(negedge I_MCLK);
    check(O_PRIV_BLOCKED, 1'b0);
    check(O_CFG_WORD, w);
    $display("run phase done");
    print_verdict();
  end
endmodule

`default_nettype wire
